/* File: alu_group_unit.sv */
// Execution unit for subtract, nibble swap, zero skip, table read and XOR instructions
//
// Overview of operation
// - Subtract to accumulator: ACC plus inverted byte plus one; four arithmetic flags.
// - Subtract to memory: same sum written to addressed byte; same four flags.
// - Subtract immediate: ACC plus inverted immediate plus one; four arithmetic flags.
// - Swap nibbles of the addressed byte in place; flags untouched.
// - Swapped byte goes to ACC; memory and flags untouched.
// - Skip when byte is zero: two cycles with dummy, else one; no flags.
// - Copy byte to ACC, skip as above when zero; no flags.
// - Skip with dummy cycle when selected bit is zero, else one cycle.
// - Paged table fetch, high pointer on: address from both pointers, low/high split.
// - Paged table fetch, high pointer off: current page plus low pointer.
// - Final page table fetch: last page at low pointer offset; no flags.
// - XOR with memory into ACC; only null result flag changes.
// - XOR written back to memory byte; only null result flag changes.
// - XOR with immediate into ACC; only null result flag changes.
`timescale 1ns/1ns
`default_nettype none

module alu_group_unit
  import alu_group_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [BUS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Program ROM
  input wire logic [ROM_PAGE_W-1:0] currentPage,
  input wire logic [ROM_DATA_W-1:0] romData,
  output rom_req_t romReq,
  // Core sequencing
  output logic busy,
  output logic discardFetch
);

  typedef struct packed {
    fsm_t fsm;
    cmd_t cmd;
    logic [7:0] acc;
    flags_t flags;
    logic [7:0] tblLow;
    logic [7:0] tblHigh;
    logic [7:0] tblLatch;
    logic highPtrEn;
    logic [MEM_ADDR_W-1:0] memPtr;
    logic lastSkipped;
    logic busy;
    logic discard;
    rom_req_t rom;
    logic waitReq;
    logic [31:0] rdData;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [7:0] mem [MEM_DEPTH];
  logic memWe;
  logic [MEM_ADDR_W-1:0] memWa;
  logic [7:0] memWd;

  // Byte-lane merge used by the command, accumulator, flag and table pointer registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Two's-complement subtract with flag results, shared by three opcodes
  function automatic flags_t subFlags(input logic [7:0] a, input logic [7:0] m, input flags_t f,
                                      output logic [7:0] r);
    flags_t nf;
    logic [8:0] full;
    logic [4:0] low;
    nf = f;
    full = {1'b0, a} + {1'b0, ~m} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
    r = full[7:0];
    nf.borrowOutFlag = full[8];
    nf.nullResultFlag = (full[7:0] == 8'h00);
    nf.auxiliaryCarryFlag = low[4];
    nf.signedWrapFlag = (a[7] != m[7]) && (full[7] != a[7]);
    return nf;
  endfunction : subFlags

  // Nibble exchange shared by the in-place and to-accumulator forms
  function automatic logic [7:0] swapNibbles(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction : swapNibbles

  // Skip test shared by the three skip forms; the bit test skips on a clear bit
  function automatic logic skipCond(input op_t op, input logic [7:0] v, input logic [2:0] sel);
    logic hit;
    if (op == OP_BIT_SKIP) begin
      hit = !v[sel];
    end else begin
      hit = (v == 8'h00);
    end
    return hit;
  endfunction : skipCond

  // Bitwise XOR whose only flag effect is the null test
  function automatic flags_t xorFlags(input logic [7:0] a, input logic [7:0] m, input flags_t f,
                                      output logic [7:0] r);
    flags_t nf;
    nf = f;
    r = a ^ m;
    nf.nullResultFlag = (r == 8'h00);
    return nf;
  endfunction : xorFlags

  logic [7:0] memByte;
  logic [7:0] subRes;
  flags_t subNf;
  logic reqTaken;
  logic [31:0] cmdWord;

  assign memByte = mem[st_ff.cmd.addr];
  // Accept only after one wait cycle, so read data is settled when the master takes it
  assign reqTaken = (read || write) && !st_ff.waitReq;
  assign cmdWord = {8'h00, st_ff.cmd.imm, 1'b0, st_ff.cmd.addr, 1'b0, st_ff.cmd.bitSel, st_ff.cmd.op};

  always_comb begin
    logic [31:0] wv;
    logic [7:0] operand;
    logic [7:0] xorRes;
    wv = 32'h0000_0000;
    xorRes = 8'h00;
    operand = (st_ff.cmd.op == OP_SUB_IMM) ? st_ff.cmd.imm : memByte;
    subNf = subFlags(st_ff.acc, operand, st_ff.flags, subRes);
    nxt_st = st_ff;
    memWe = 1'b0;
    memWa = st_ff.cmd.addr;
    memWd = 8'h00;
    nxt_st.rom.rd = 1'b0;
    nxt_st.discard = 1'b0;

    // Answer one cycle after a request is seen; data stands at the accepting edge
    nxt_st.waitReq = !((read || write) && st_ff.waitReq);
    if (read && st_ff.waitReq) begin
      case (address)
        REG_COMMAND: nxt_st.rdData = cmdWord;
        REG_ACCUM: nxt_st.rdData = {24'h000000, st_ff.acc};
        REG_FLAGS: nxt_st.rdData = {26'h0, st_ff.flags};
        REG_TBL_LOW: nxt_st.rdData = {24'h000000, st_ff.tblLow};
        REG_TBL_HIGH: nxt_st.rdData = {24'h000000, st_ff.tblHigh};
        REG_TBL_LATCH: nxt_st.rdData = {24'h000000, st_ff.tblLatch};
        REG_CONTROL: nxt_st.rdData = {31'h0, st_ff.highPtrEn};
        REG_EXEC_STATUS: nxt_st.rdData = {30'h0, st_ff.lastSkipped, st_ff.busy};
        REG_MEM_PTR: nxt_st.rdData = {25'h0, st_ff.memPtr};
        REG_MEM_DATA: nxt_st.rdData = {24'h000000, mem[st_ff.memPtr]};
        default: nxt_st.rdData = 32'h0000_0000;
      endcase
    end

    // Register writes take effect at the accepting edge; unmapped writes are dropped
    if (write && reqTaken) begin
      case (address)
        REG_COMMAND: begin
          // A command during execution is ignored; software polls the busy bit first
          if (st_ff.fsm == ST_IDLE) begin
            wv = merge(cmdWord, writedata, byteenable);
            nxt_st.cmd.op = op_t'(wv[CMD_OP_LSB +: 4]);
            nxt_st.cmd.bitSel = wv[CMD_BIT_LSB +: 3];
            nxt_st.cmd.addr = wv[CMD_ADDR_LSB +: MEM_ADDR_W];
            nxt_st.cmd.imm = wv[CMD_IMM_LSB +: 8];
            nxt_st.fsm = ST_EXEC;
            nxt_st.busy = 1'b1;
            nxt_st.lastSkipped = 1'b0;
          end
        end
        REG_ACCUM: begin
          wv = merge({24'h000000, st_ff.acc}, writedata, byteenable);
          nxt_st.acc = wv[7:0];
        end
        REG_FLAGS: begin
          wv = merge({26'h0, st_ff.flags}, writedata, byteenable);
          nxt_st.flags = flags_t'(wv[5:0]);
        end
        REG_TBL_LOW: begin
          wv = merge({24'h000000, st_ff.tblLow}, writedata, byteenable);
          nxt_st.tblLow = wv[7:0];
        end
        REG_TBL_HIGH: begin
          wv = merge({24'h000000, st_ff.tblHigh}, writedata, byteenable);
          nxt_st.tblHigh = wv[7:0];
        end
        REG_CONTROL: begin
          if (byteenable[0]) begin
            nxt_st.highPtrEn = writedata[CTRL_HIGH_PTR_BIT];
          end
        end
        REG_MEM_PTR: begin
          if (byteenable[0]) begin
            nxt_st.memPtr = writedata[MEM_ADDR_W-1:0];
          end
        end
        REG_MEM_DATA: begin
          // Software write is taken only while the unit is idle, so it never meets an instruction write
          if (byteenable[0] && st_ff.fsm == ST_IDLE) begin
            memWe = 1'b1;
            memWa = st_ff.memPtr;
            memWd = writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Instruction sequencing; watchdog and powerdown bits are never touched here
    case (st_ff.fsm)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        nxt_st.fsm = ST_IDLE;
        nxt_st.busy = 1'b0;
        case (st_ff.cmd.op)
          OP_SUB_ACC, OP_SUB_IMM: begin
            nxt_st.acc = subRes;
            nxt_st.flags = subNf;
          end
          OP_MINUS_MEM: begin
            memWe = 1'b1;
            memWd = subRes;
            nxt_st.flags = subNf;
          end
          OP_NIBBLE_SWAP: begin
            memWe = 1'b1;
            memWd = swapNibbles(memByte);
          end
          OP_NIBBLE_EXCHANGE_ACC: begin
            nxt_st.acc = swapNibbles(memByte);
          end
          OP_SKIP_NULL, OP_COPY_SKIP_NULL, OP_BIT_SKIP: begin
            if (st_ff.cmd.op == OP_COPY_SKIP_NULL) begin
              nxt_st.acc = memByte;
            end
            // Prefetched word is thrown away through a dummy cycle
            if (skipCond(st_ff.cmd.op, memByte, st_ff.cmd.bitSel)) begin
              nxt_st.fsm = ST_DUMMY;
              nxt_st.busy = 1'b1;
              nxt_st.discard = 1'b1;
              nxt_st.lastSkipped = 1'b1;
            end
          end
          OP_TABLE_PAGED, OP_TABLE_FINAL: begin
            nxt_st.fsm = ST_ROM;
            nxt_st.busy = 1'b1;
            nxt_st.rom.rd = 1'b1;
            if (st_ff.cmd.op == OP_TABLE_FINAL) begin
              nxt_st.rom.addr = {LAST_PAGE, st_ff.tblLow};
            end else if (st_ff.highPtrEn) begin
              // Only the high pointer bits that select a page are used; the rest are ignored
              nxt_st.rom.addr = {st_ff.tblHigh[ROM_PAGE_W-1:0], st_ff.tblLow};
            end else begin
              nxt_st.rom.addr = {currentPage, st_ff.tblLow};
            end
          end
          OP_XOR_ACC, OP_XOR_IMM: begin
            operand = (st_ff.cmd.op == OP_XOR_IMM) ? st_ff.cmd.imm : memByte;
            nxt_st.flags = xorFlags(st_ff.acc, operand, st_ff.flags, xorRes);
            nxt_st.acc = xorRes;
          end
          OP_XOR_MEM: begin
            nxt_st.flags = xorFlags(st_ff.acc, memByte, st_ff.flags, xorRes);
            memWe = 1'b1;
            memWd = xorRes;
          end
          default: begin
          end
        endcase
      end
      ST_DUMMY: begin
        nxt_st.fsm = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
      ST_ROM: begin
        // ROM answers in the same cycle as the strobe; flags stay as they are
        memWe = 1'b1;
        memWd = romData[7:0];
        nxt_st.tblLatch = romData[15:8];
        nxt_st.fsm = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
      default: begin
        nxt_st.fsm = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff.fsm <= ST_IDLE;
      st_ff.cmd <= '0;
      st_ff.acc <= ACC_RESET;
      st_ff.flags <= FLAGS_RESET;
      st_ff.tblLow <= TBL_RESET;
      st_ff.tblHigh <= TBL_RESET;
      st_ff.tblLatch <= TBL_RESET;
      st_ff.highPtrEn <= HIGH_PTR_RESET;
      st_ff.memPtr <= '0;
      st_ff.lastSkipped <= 1'b0;
      st_ff.busy <= 1'b0;
      st_ff.discard <= 1'b0;
      st_ff.rom <= '0;
      st_ff.waitReq <= 1'b1;
      st_ff.rdData <= 32'h0000_0000;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  // Data memory has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (clkEn && memWe) begin
      mem[memWa] <= memWd;
    end
  end

  assign readdata = st_ff.rdData;
  assign waitrequest = st_ff.waitReq;
  assign romReq = st_ff.rom;
  assign busy = st_ff.busy;
  assign discardFetch = st_ff.discard;

endmodule : alu_group_unit

`default_nettype wire

/* File: alu_group_pkg.sv */
// Constants, types and register map of the subtract, swap, skip, table and XOR unit
package alu_group_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_ACCUM = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_TBL_LOW = 8'h0c;
  localparam logic [7:0] REG_TBL_HIGH = 8'h10;
  localparam logic [7:0] REG_TBL_LATCH = 8'h14;
  localparam logic [7:0] REG_CONTROL = 8'h18;
  localparam logic [7:0] REG_EXEC_STATUS = 8'h1c;
  localparam logic [7:0] REG_MEM_PTR = 8'h20;
  localparam logic [7:0] REG_MEM_DATA = 8'h24;

  // Widths
  localparam int BUS_ADDR_W = 8;
  localparam int MEM_ADDR_W = 7;
  localparam int MEM_DEPTH = 128;
  localparam int ROM_ADDR_W = 12;
  localparam int ROM_PAGE_W = 4;
  localparam int ROM_DATA_W = 16;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  // Control and execution status bit positions
  localparam int CTRL_HIGH_PTR_BIT = 0;
  localparam int EXEC_BUSY_BIT = 0;
  localparam int EXEC_SKIPPED_BIT = 1;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] TBL_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic HIGH_PTR_RESET = 1'b1;

  // Page that the final-page table fetch reads
  localparam logic [ROM_PAGE_W-1:0] LAST_PAGE = 4'hf;

  typedef enum logic [3:0] {
    OP_SUB_ACC = 4'h0,
    OP_MINUS_MEM = 4'h1,
    OP_SUB_IMM = 4'h2,
    OP_NIBBLE_SWAP = 4'h3,
    OP_NIBBLE_EXCHANGE_ACC = 4'h4,
    OP_SKIP_NULL = 4'h5,
    OP_COPY_SKIP_NULL = 4'h6,
    OP_BIT_SKIP = 4'h7,
    OP_TABLE_PAGED = 4'h8,
    OP_TABLE_FINAL = 4'h9,
    OP_XOR_ACC = 4'ha,
    OP_XOR_MEM = 4'hb,
    OP_XOR_IMM = 4'hc
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_DUMMY = 4'b0100,
    ST_ROM = 4'b1000
  } fsm_t;

  typedef struct packed {
    logic watchdogExpiredFlag;
    logic powerdownFlag;
    logic signedWrapFlag;
    logic nullResultFlag;
    logic auxiliaryCarryFlag;
    logic borrowOutFlag;
  } flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [MEM_ADDR_W-1:0] addr;
    logic [2:0] bitSel;
    op_t op;
  } cmd_t;

  typedef struct packed {
    logic [ROM_ADDR_W-1:0] addr;
    logic rd;
  } rom_req_t;

endpackage : alu_group_pkg

/* File: alu_group_properties.sv */
// Port-level checker for the subtract, swap, skip, table and XOR unit
`timescale 1ns/1ns
`default_nettype none
module alu_group_properties
  import alu_group_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // Register bus
  input wire logic [BUS_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Sequencing
  input wire rom_req_t romReq,
  input wire logic busy,
  input wire logic discardFetch
);
  // A frozen clock enable stretches every pulse, so those cycles are not judged
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !clkEn);

  AST_ACCEPT_NEXT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not accepted one cycle after it was seen");
  AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_WAIT_CAUSE: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("waitrequest fell without a request");
  AST_BUSY_START: assert property ($rose(busy) |-> $past(write && !waitrequest && address == REG_COMMAND))
    else $error("busy rose without an accepted command write");
  AST_BUSY_LEN: assert property ($rose(busy) |-> ##2 !busy)
    else $error("instruction lasted more than two cycles");
  AST_DISCARD_SLOT: assert property (discardFetch |-> busy && $past(busy) ##1 !discardFetch && !busy)
    else $error("discard pulse outside the dummy cycle");
  AST_DISCARD_EXCL: assert property (discardFetch |-> !romReq.rd)
    else $error("discard and table read together");
  AST_ROM_SLOT: assert property (romReq.rd |-> busy && $past(busy) ##1 !romReq.rd && !busy && $stable(romReq.addr))
    else $error("table read pulse misplaced");
  AST_SECOND_CYCLE: assert property (busy && $past(busy) |-> discardFetch || romReq.rd)
    else $error("second busy cycle without skip or table read");
endmodule : alu_group_properties

bind alu_group_unit alu_group_properties i_props (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .address(address),
  .read(read), .write(write), .waitrequest(waitrequest), .romReq(romReq), .busy(busy), .discardFetch(discardFetch));
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the subtract, swap, skip, table and XOR unit
`timescale 1ns/1ns
`default_nettype none
module testbench
  import alu_group_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] currentPage = 4'h6;
  wire logic [15:0] romData;
  rom_req_t romReq;
  logic busy;
  logic discardFetch;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int nBusy = 0;
  int nDisc = 0;
  logic [31:0] q;
  logic [13:0] e;
  logic [7:0] mv;
  logic [3:0] ops[6] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'hb, 4'hc};
  logic [7:0] va[4] = '{8'h05, 8'h03, 8'h80, 8'h3c};
  logic [7:0] vb[4] = '{8'h03, 8'h05, 8'h01, 8'h3c};
  logic [3:0] sOp[6] = '{4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7};
  logic [2:0] sBit[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0};
  logic [7:0] sMem[6] = '{8'h00, 8'h80, 8'h00, 8'h42, 8'h7f, 8'h01};
  logic sSkip[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #25 ref_clk = ~ref_clk;
  // ROM image: high byte shows page and upper offset, so the latch proves the address
  assign romData = {romReq.addr[11:4], romReq.addr[7:0] ^ 8'h3c};

  alu_group_unit i_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .address(address), .read(read), .write(write),
    .byteenable(4'hf), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .currentPage(currentPage), .romData(romData), .romReq(romReq), .busy(busy), .discardFetch(discardFetch));

  // Negedge sampling avoids racing the registered outputs
  always @(negedge ref_clk) begin
    cyc++;
    nBusy += (busy === 1'b1);
    nDisc += (discardFetch === 1'b1);
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    // Waitrequest and readdata are taken at the rising edge, before the design updates them
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) bad_count++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic mem(input logic w, input logic [6:0] m, input logic [7:0] v);
    bus(1'b1, REG_MEM_PTR, {25'h0, m});
    bus(w, REG_MEM_DATA, {24'h0, v});
  endtask : mem

  task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [6:0] m, input logic [7:0] imm);
    int n;
    n = 0;
    nBusy = 0;
    nDisc = 0;
    bus(1'b1, REG_COMMAND, {8'h00, imm, 1'b0, m, 1'b0, b, op});
    do begin
      bus(1'b0, REG_EXEC_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 5);
    if (n >= 5) bad_count++;
  endtask : run

  // Returns flags and result; flags keep the two status bits this group never touches
  function automatic logic [13:0] model(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
      input logic [5:0] f);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~b} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    if (op >= 4'ha) return {f[5:3], (a ^ b) == 8'h00, f[1:0], a ^ b};
    return {f[5:4], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : model

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, REG_ACCUM, 32'h0);
    chk("accReset", q, 32'h0);
    bus(1'b0, REG_CONTROL, 32'h0);
    chk("ctrlReset", q, 32'h1);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", q, 32'h0);
    foreach (ops[i]) for (int k = 0; k < 4; k++) begin
      e = model(ops[i], va[k], vb[k], ((i + k) % 2) ? 6'h3f : 6'h30);
      // Immediate forms get a different memory byte, so a wrong operand source shows
      mv = (ops[i] == 4'h2 || ops[i] == 4'hc) ? ~vb[k] : vb[k];
      bus(1'b1, REG_ACCUM, {24'h0, va[k]});
      mem(1'b1, 7'h11, mv);
      bus(1'b1, REG_FLAGS, {26'h0, e[13:12], 4'h0} | (((i + k) % 2) ? 32'h3f : 32'h30));
      run(ops[i], 3'h0, 7'h11, vb[k]);
      bus(1'b0, REG_ACCUM, 32'h0);
      chk("acc", q, (ops[i] == 4'h1 || ops[i] == 4'hb) ? va[k] : e[7:0]);
      mem(1'b0, 7'h11, 8'h00);
      chk("mem", q, (ops[i] == 4'h1 || ops[i] == 4'hb) ? e[7:0] : mv);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk("flags", q, e[13:8]);
    end
    mem(1'b1, 7'h22, 8'h1e);
    bus(1'b1, REG_FLAGS, 32'h2a);
    run(4'h3, 3'h0, 7'h22, 8'h00);
    run(4'h4, 3'h0, 7'h22, 8'h00);
    bus(1'b0, REG_ACCUM, 32'h0);
    chk("swapAcc", q, 32'h1e);
    mem(1'b0, 7'h22, 8'h00);
    chk("swapMem", q, 32'he1);
    foreach (sOp[i]) begin
      mem(1'b1, 7'h33, sMem[i]);
      bus(1'b1, REG_ACCUM, 32'h99);
      run(sOp[i], sBit[i], 7'h33, 8'h00);
      chk("busyCycles", nBusy, sSkip[i] ? 2 : 1);
      chk("discards", nDisc, sSkip[i]);
      chk("skipped", q, {30'h0, sSkip[i], 1'b0});
      bus(1'b0, REG_ACCUM, 32'h0);
      chk("skipAcc", q, (sOp[i] == 4'h6) ? sMem[i] : 8'h99);
    end
    bus(1'b1, REG_TBL_LOW, 32'hc4);
    bus(1'b1, REG_TBL_HIGH, 32'h03);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, REG_CONTROL, (i == 0) ? 32'h1 : 32'h0);
      run((i == 2) ? 4'h9 : 4'h8, 3'h0, 7'h44 + i[6:0], 8'h00);
      chk("tableBusy", nBusy, 2);
      mem(1'b0, 7'h44 + i[6:0], 8'h00);
      chk("tableLow", q, 32'hf8);
      bus(1'b1, REG_TBL_LATCH, 32'hff);
      bus(1'b0, REG_TBL_LATCH, 32'h0);
      chk("tableHigh", q, (i == 0) ? 32'h3c : (i == 1) ? 32'h6c : 32'hfc);
    end
    bus(1'b0, REG_FLAGS, 32'h0);
    chk("flagsKept", q, 32'h2a);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
